// file: src/eeprom_rd_consts.vh
// Constants for the two-wire serial memory read sequencer.
// Included by the sequencer and its array module; definitions only.
`ifndef EEPROM_RD_CONSTS_VH
`define EEPROM_RD_CONSTS_VH
// Device-type code in the top four bits of the slave address (arbitrary)
`define DEV_TYPE_CODE 4'h5
`define BITS_PER_BYTE 4'h8
`define ACK_BIT_IDX 4'h8
// Bit count held between START and the first falling clock
`define BIT_BEFORE_FIRST 4'hf
`define ADDR_LO_BITS 8
`define RW_READ 1'b1
`define RW_WRITE 1'b0
`endif

// file: src/eeprom_array.v
// Byte-wide memory array for the read sequencer.
// Assumes one clock; read data are registered one cycle after the address.
`timescale 1ns/100ps
`include "eeprom_rd_consts.vh"
module eeprom_array #(
  parameter AW = 13
) (
  // Clock
  input wire clk_i,
  // Write port
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [7:0] wr_data_i,
  // Read port
  input wire [AW-1:0] rd_addr_i,
  output reg [7:0] rd_data_o
);
  reg [7:0] mem [0:(1<<AW)-1];

  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// file: src/eeprom_read_seq.v
// Read-side command sequencer of a two-wire serial memory slave.
// Assumes serial clock and data are synchronous samples of the bus pins;
// the data pin is open drain, driven low when sda_oe_n_o is low.
// Operation
// RL1: After master ack, shift out next byte from incremented counter.
// RL2: Master acks in 27th clock to request a third byte.
// RL3: Sequential read continues while master acks each byte.
// RL4: Counter wraps from highest array address to address zero.
// RL5: Master ends read with no-ack then STOP.
// RL6: Random read starts with START and write-direction address byte.
// RL7: Two word-address bytes load the counter; device acks them.
// RL8: Master sends no data; restarts into current address read.
// RL9: START after dummy write cancels pending programming.
// RL10: Device acks each received byte by pulling data low at clock 9.
// RL11: Address byte holds type code, select bits, direction; mismatch idles.
// RL12: Counter increments by one after each byte shifted out.
// RL13: STOP after read returns device to standby.
// RL14: Release data during master ack slot; stop on no-ack.
// RL15: Counter is 12 or 13 bits; unused high address bits ignored.
`timescale 1ns/100ps
`include "eeprom_rd_consts.vh"
module eeprom_read_seq #(
  parameter AW = 13
) (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Bus pins
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_n_o,
  // Chip select straps
  input wire [2:0] chip_select_address_pins_i,
  // Write path into the array, taken when no restart cancels it
  output reg prog_en_o,
  output reg [AW-1:0] prog_addr_o,
  output reg [7:0] prog_data_o,
  // Status
  output wire standby_o,
  output wire [AW-1:0] word_addr_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_DEVADDR = 3'h1;
  localparam ST_ADDR_HI = 3'h2;
  localparam ST_ADDR_LO = 3'h3;
  localparam ST_WDATA = 3'h4;
  localparam ST_READ = 3'h5;

  reg [2:0] state_r;
  reg scl_d_r;
  reg sda_d_r;
  reg [3:0] bit_r;
  reg [7:0] shift_r;
  reg [7:0] tx_r;
  reg [AW-1:0] addr_r;
  reg [7:0] hi_r;
  reg drive_low_r;
  reg ack_slot_r;
  reg pend_r;
  reg [7:0] pend_data_r;
  reg [AW-1:0] pend_addr_r;
  wire [7:0] rd_data;

  // Edge and bus-condition detectors on the sampled pins
  wire scl_rise = scl_i & ~scl_d_r;
  wire scl_fall = ~scl_i & scl_d_r;
  wire start_det = scl_i & scl_d_r & sda_d_r & ~sda_i;
  wire stop_det = scl_i & scl_d_r & ~sda_d_r & sda_i;
  wire [7:0] rx_byte = {shift_r[6:0], sda_i};
  wire last_bit = (bit_r == `BITS_PER_BYTE - 4'h1);
  // Wraps from the top of the array to zero by width alone
  wire [AW-1:0] addr_inc = addr_r + {{(AW-1){1'b0}}, 1'b1}; // RL4
  // Upper address bits beyond AW are dropped
  wire [15:0] addr_full = {hi_r, rx_byte};
  wire [AW-1:0] addr_load = addr_full[AW-1:0]; // RL15
  // Master ack slot of a read byte, not the device's own address ack
  wire rd_ack_slot = (state_r == ST_READ) & ~ack_slot_r;

  // Read port follows the counter, so the next byte is prefetched
  eeprom_array #(
    .AW(AW)
  ) u_array (
    .clk_i(clk_i),
    .wr_en_i(prog_en_o),
    .wr_addr_i(prog_addr_o),
    .wr_data_i(prog_data_o),
    .rd_addr_i(addr_r),
    .rd_data_o(rd_data)
  );

  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~drive_low_r;
  assign standby_o = (state_r == ST_IDLE);
  assign word_addr_o = addr_r;

  always @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      addr_r <= {AW{1'b0}};
      hi_r <= 8'h00;
      drive_low_r <= 1'b0;
      ack_slot_r <= 1'b0;
      pend_r <= 1'b0;
      pend_data_r <= 8'h00;
      pend_addr_r <= {AW{1'b0}};
      prog_en_o <= 1'b0;
      prog_addr_o <= {AW{1'b0}};
      prog_data_o <= 8'h00;
    end else begin
      scl_d_r <= scl_i;
      sda_d_r <= sda_i;
      prog_en_o <= 1'b0;
      if (start_det) begin
        // A restart drops any pending write
        pend_r <= 1'b0; // RL9
        state_r <= ST_DEVADDR;
        // The fall after START is no bit; the count wraps to zero there
        bit_r <= `BIT_BEFORE_FIRST;
        drive_low_r <= 1'b0;
        ack_slot_r <= 1'b0;
      end else if (stop_det) begin
        if (pend_r) begin
          prog_en_o <= 1'b1;
          prog_addr_o <= pend_addr_r;
          prog_data_o <= pend_data_r;
        end
        pend_r <= 1'b0;
        state_r <= ST_IDLE; // RL13
        drive_low_r <= 1'b0;
        ack_slot_r <= 1'b0;
      end else if (state_r != ST_IDLE) begin
        if (scl_rise) begin
          if (bit_r == `ACK_BIT_IDX) begin
            // Own address ack in read state is skipped
            if (rd_ack_slot) begin
              if (sda_i) begin
                // No ack: give up the line until START
                state_r <= ST_IDLE; // RL5
              end else begin
                tx_r <= rd_data; // RL1
                addr_r <= addr_inc; // RL3
              end
            end
          end else begin
            shift_r <= rx_byte;
            if (last_bit) begin
              case (state_r)
                ST_DEVADDR: begin
                  if (rx_byte[7:1] == {`DEV_TYPE_CODE,
                      chip_select_address_pins_i}) begin // RL11
                    if (rx_byte[0] == `RW_READ) begin
                      state_r <= ST_READ;
                      tx_r <= rd_data;
                      addr_r <= addr_inc; // RL12
                    end else begin
                      state_r <= ST_ADDR_HI; // RL6
                    end
                    ack_slot_r <= 1'b1;
                  end else begin
                    state_r <= ST_IDLE; // RL11
                  end
                end
                ST_ADDR_HI: begin
                  hi_r <= rx_byte;
                  state_r <= ST_ADDR_LO; // RL7
                  ack_slot_r <= 1'b1;
                end
                ST_ADDR_LO: begin
                  addr_r <= addr_load; // RL7
                  state_r <= ST_WDATA; // RL8
                  ack_slot_r <= 1'b1;
                end
                ST_WDATA: begin
                  pend_r <= 1'b1;
                  pend_data_r <= rx_byte;
                  pend_addr_r <= addr_r;
                  // Counter moves on even if a restart cancels the write
                  addr_r <= addr_inc; // RL4
                  ack_slot_r <= 1'b1;
                end
                ST_READ: begin
                  ack_slot_r <= 1'b0;
                end
                default: begin
                  state_r <= ST_IDLE;
                end
              endcase
            end
          end
        end
        if (scl_fall) begin
          if (bit_r == `ACK_BIT_IDX) begin
            bit_r <= 4'h0;
            ack_slot_r <= 1'b0;
            // First data bit of next read byte
            drive_low_r <= (state_r == ST_READ) & ~tx_r[7]; // RL1
          end else if (last_bit) begin
            bit_r <= `ACK_BIT_IDX;
            // Ack write bytes; release during master ack slot
            drive_low_r <= ack_slot_r; // RL10 RL14
          end else begin
            bit_r <= bit_r + 4'h1;
            if (state_r == ST_READ) begin
              drive_low_r <= ~tx_r[3'h6 - bit_r[2:0]];
            end else begin
              drive_low_r <= 1'b0;
            end
          end
        end
      end else begin
        // Standby: line released and bits ignored until START
        drive_low_r <= 1'b0; // RL14
      end
    end
  end
endmodule

// file: bench/eeprom_read_seq_props.sv
// Port assertions for the read sequencer.
// Bound into every sequencer; sees its ports only.
`timescale 1ns/100ps
module eeprom_read_seq_props #(
  parameter AW = 13
) (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Bus
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_n_o,
  // Status
  input wire prog_en_o,
  input wire standby_o,
  input wire [AW-1:0] word_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Clock rises counted since the last START, saturating
  logic scl_q_r;
  logic sda_q_r;
  logic [3:0] rise_cnt_r;
  always @(posedge clk_i) begin
    if (reset_i) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      rise_cnt_r <= 4'hf;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
      if (scl_i && scl_q_r && sda_q_r && !sda_i) begin
        rise_cnt_r <= 4'h0;
      end else if (scl_i && !scl_q_r && rise_cnt_r != 4'hf) begin
        rise_cnt_r <= rise_cnt_r + 4'h1;
      end
    end
  end
  sequence s_hi; scl_i && $past(scl_i); endsequence
  sequence s_start; s_hi ##0 $fell(sda_i); endsequence
  sequence s_stop; s_hi ##0 $rose(sda_i); endsequence
  a_oe_after_fall: assert property ($changed(sda_oe_n_o) |->
    !$past(scl_i) && $past(scl_i, 2)) else $error("drive off fall");
  a_no_early_drive: assert property (!sda_oe_n_o |->
    !sda_o && rise_cnt_r >= 4'h8) else $error("drive inside address byte");
  a_standby_quiet: assert property (standby_o |-> sda_oe_n_o)
    else $error("drive in standby");
  a_stop_standby: assert property (s_stop |-> ##[1:4] standby_o)
    else $error("no standby");
  a_bus_cond_free: assert property (s_hi ##0 $changed(sda_i) |->
    sda_oe_n_o && $past(sda_oe_n_o)) else $error("drive at bus edge");
  a_prog_at_stop: assert property (prog_en_o |->
    scl_i && sda_i ##1 !prog_en_o) else $error("bad commit");
  a_start_no_prog: assert property (s_start |-> !prog_en_o [*4])
    else $error("commit after start");
  a_idle_addr_hold: assert property (standby_o && $past(standby_o) |->
    $stable(word_addr_o)) else $error("counter moved idle");
endmodule
bind eeprom_read_seq eeprom_read_seq_props #(.AW(AW)) chk (
  .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .prog_en_o(prog_en_o),
  .standby_o(standby_o), .word_addr_o(word_addr_o));

// file: bench/bus_master_model.sv
// Two-wire bus master model driving clock and its data line.
// Assumes the bench resolves the wired data level into sda_w_i.
`timescale 1ns/100ps
module bus_master_model (
  input wire clk_i,
  input wire sda_w_i,
  output reg scl_o,
  output reg sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task tk(input integer n); repeat (n) @(posedge clk_i); endtask
  task xfer(input b, output r); begin
    sda_o <= b; tk(2); scl_o <= 1'b1; tk(2); r = sda_w_i; tk(2);
    scl_o <= 1'b0; tk(2);
  end endtask
  task start; begin
    sda_o <= 1'b1; tk(2); scl_o <= 1'b1; tk(3); sda_o <= 1'b0; tk(3);
    scl_o <= 1'b0; tk(2);
  end endtask
  task stop; begin
    sda_o <= 1'b0; tk(2); scl_o <= 1'b1; tk(3); sda_o <= 1'b1; tk(3);
  end endtask
  // Eight bits MSB first, then the acknowledge slot
  task byte_io(input [7:0] d, input ak, output [7:0] q, output a);
    integer i; begin
    for (i = 7; i >= 0; i = i - 1) xfer(d[i], q[i]);
    xfer(ak, a);
  end endtask
endmodule

// file: bench/eeprom_read_seq_tb.sv
// Self-checking bench for the read sequencer.
// Drives the bus through the master model; select straps set by the bench.
`timescale 1ns/100ps
`include "eeprom_rd_consts.vh"
module eeprom_read_seq_tb;
  localparam AW = 13;
  localparam [7:0] DEV = {`DEV_TYPE_CODE, 3'h5, 1'b0};
  reg clk_i = 1'b0;
  reg reset_i = 1'b1;
  wire scl, msda, sda_o, oe_n, sby, pen;
  wire [AW-1:0] pa, wa;
  wire [7:0] pd;
  wire sda = msda & (oe_n | sda_o);
  integer err_count = 0, n_checks = 0, cyc = 0, np = 0, i;
  reg a;
  reg [7:0] q;
  reg [AW-1:0] w;
  reg [2:0] cs_pins = 3'h5;
  initial forever #2 clk_i = ~clk_i;
  eeprom_read_seq #(.AW(AW)) uut (.clk_i(clk_i), .reset_i(reset_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(oe_n),
    .chip_select_address_pins_i(cs_pins), .prog_en_o(pen), .prog_addr_o(pa),
    .prog_data_o(pd), .standby_o(sby), .word_addr_o(wa));
  bus_master_model m (.clk_i(clk_i), .sda_w_i(sda), .scl_o(scl),
    .sda_o(msda));
  task chk(input [23:0] s, input [23:0] e); begin
    n_checks = n_checks + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("ERROR %0t: seen %h want %h", $time, s, e);
    end
  end endtask
  task end_sim; begin
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  end endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (pen === 1'b1) np <= np + 1;
    if (cyc == 40000) begin
      err_count = err_count + 1;
      end_sim;
    end
  end
  task wb(input [7:0] d); begin
    m.byte_io(d, 1'b1, q, a); chk(a, 0);
  end endtask
  task seta(input [AW-1:0] ad); begin
    m.start; wb(DEV); wb({3'h0, ad[12:8]}); wb(ad[7:0]);
  end endtask
  task t_write(input [AW-1:0] ad); begin
    seta(ad); wb(ad[7:0] ^ 8'h3c); m.stop; m.tk(2);
    chk({pa, pd}, {ad, ad[7:0] ^ 8'h3c});
  end endtask
  task t_read(input [AW-1:0] ad, input integer n, input cancel);
    integer p; begin
    p = np;
    seta(ad);
    if (cancel) begin
      // The dummy data byte moves the counter before the restart
      wb(8'hee);
      ad = ad + 1'b1;
    end
    m.start; wb(DEV | 8'h01);
    for (i = 0; i < n; i = i + 1) begin
      m.byte_io(8'hff, i == n - 1, q, a);
      chk(q, ad[7:0] ^ 8'h3c);
      ad = ad + 1'b1;
    end
    m.stop; m.tk(4);
    chk({sby, oe_n, wa}, {2'b11, ad});
    chk(np, p);
  end endtask
  task t_miss; begin
    m.start; m.byte_io({`DEV_TYPE_CODE, 3'h2, 1'b1}, 1'b1, q, a);
    chk({a, sby}, 2'b11); m.stop;
    m.start; m.byte_io({4'h3, 3'h5, 1'b1}, 1'b1, q, a);
    chk({a, sby}, 2'b11); m.stop;
    cs_pins <= 3'h2;
    m.tk(2);
    m.start;
    wb({`DEV_TYPE_CODE, 3'h2, 1'b0});
    m.stop;
    m.tk(4);
    chk(sby, 1'b1);
    cs_pins <= 3'h5;
  end endtask
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    m.tk(2);
    w = 13'h1ffe;
    repeat (3) begin
      t_write(w);
      w = w + 1'b1;
    end
    t_read(13'h1ffe, 3, 1'b0);
    t_read(13'h1fff, 1, 1'b1);
    t_miss;
    end_sim;
  end
endmodule
